// ==== verilog/clock_event_flags_and_bus_gating.sv ====
// Oscillator event flags, their clear and enable, and fast-bus clock gates
// How it works
// - Bits 15..11 show live oscillator stability
// - Bits 4..0 latch oscillator ready events
// - Bits 8,7 latch crystal run stops
// - Bits 6,5 latch crystal start failures
// - Flags at 0x10, reset 0x801
// - Writing zero clears flag; one ignored
// - Clear register 0x14 reads 0x1FF
// - Clear bits map one-to-one onto flags
// - Bits 11,10 gate cipher and random
// - Bits 9..4 gate ports F..A
// - Bit 2 gates checksum clocks
// - Bit 1 gates flash configuration clock
// - Bit 0 gates DMA clocks
// - Gates at 0x30, reset all off
// - Enable register needs key 0x5A5A
// - Run failures raise fault interrupt, others clock
`timescale 1ns/1ps
module clock_event_flags_and_bus_gating
  import clock_event_pkg::*;
(
  input  wire logic        hclk,              // Bus clock, 10 MHz
  input  wire logic        hresetn,           // Async reset, active low
  input  wire logic        hsel,              // Slave select
  input  wire logic [31:0] haddr,             // Byte address
  input  wire logic [1:0]  htrans,            // Transfer type
  input  wire logic        hwrite,            // Write when high
  input  wire logic [2:0]  hsize,             // Transfer size
  input  wire logic [31:0] hwdata,            // Write data
  input  wire logic        hready,            // Bus ready
  output logic      [31:0] hrdata,            // Read data
  output logic             hreadyout,         // Slave ready
  output logic             hresp,             // Response, always OKAY
  input  wire logic [4:0]  osc_stable,        // Slow xtal, slow int, loop, fast xtal, fast int
  input  wire logic        slow_xtal_no_start,// Slow crystal start failed
  input  wire logic        fast_xtal_no_start,// Fast crystal start failed
  input  wire logic        slow_xtal_stopped, // Slow crystal stopped running
  input  wire logic        fast_xtal_stopped, // Fast crystal stopped running
  output logic             fault_irq,         // Run-failure interrupt
  output logic             clock_irq,         // Clock-control interrupt
  output logic             cipher_clk_en,     // Cipher clocks on
  output logic             random_source_module_clk_en, // Random source clocks on
  output logic      [5:0]  io_port_clk_en,    // Ports F..A clocks on
  output logic             checksum_clk_en,   // Checksum clocks on
  output logic             flash_cfg_clk_en,  // Flash configuration clock on
  output logic             dma_clk_en         // DMA clocks on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t      st_q;
  state_t      st_d;
  logic [8:0]  sync_in;
  logic [8:0]  rise;
  logic [8:0]  clr_mask;
  logic        take;
  logic        wr_fire;

  assign sync_in = {fast_xtal_stopped, slow_xtal_stopped, fast_xtal_no_start,
                    slow_xtal_no_start, osc_stable};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Three-stage input synchroniser, change taken once stages 2 and 3 agree
    st_d.s1     = sync_in;
    st_d.s2     = st_q.s1;
    st_d.s3     = st_q.s2;
    st_d.agreed = (st_q.s2 & st_q.s3) | (st_q.agreed & (st_q.s2 | st_q.s3));
    rise        = st_d.agreed & ~st_q.agreed;

    wr_fire  = st_q.wr_pend;
    clr_mask = 9'h000;
    if (wr_fire && st_q.wr_addr == EVENT_CLEAR_OFS) begin
      clr_mask = ~hwdata[LATCH_MSB:0];
    end
    // Set wins over a clear in the same cycle
    st_d.flags = (st_q.flags & ~clr_mask) | rise;

    if (wr_fire && st_q.wr_addr == BUS_GATES_OFS) begin
      st_d.gates = hwdata[11:0] & BUS_GATES_MASK;
    end
    if (wr_fire && st_q.wr_addr == IRQ_ENABLE_OFS &&
        hwdata[31:KEY_LSB] == IRQ_ENABLE_KEY) begin
      st_d.ie = hwdata[LATCH_MSB:0];
    end

    // Address phase
    take         = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
    st_d.wr_pend = take && hwrite;
    st_d.wr_addr = haddr[7:0];
    st_d.rdata   = 32'h0000_0000;
    if (take && !hwrite) begin
      // Read from next values so a write just finishing is seen
      case (haddr[7:0])
        IRQ_ENABLE_OFS:  st_d.rdata = {23'h000000, st_d.ie};
        EVENT_FLAGS_OFS: st_d.rdata = {16'h0000, st_d.agreed[4:0], 2'h0, st_d.flags};
        EVENT_CLEAR_OFS: st_d.rdata = EVENT_CLEAR_RB;
        BUS_GATES_OFS:   st_d.rdata = {20'h00000, st_d.gates};
        default:         st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.ready = 1'b1;
    st_d.resp  = 1'b0;

    st_d.irq_fault = |(st_q.flags & st_q.ie & RUN_FAULT_MASK);
    st_d.irq_clock = |(st_q.flags & st_q.ie & ~RUN_FAULT_MASK);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.s1        <= SYNC_RST;
      st_q.s2        <= SYNC_RST;
      st_q.s3        <= SYNC_RST;
      st_q.agreed    <= SYNC_RST;
      st_q.flags     <= EVENT_FLAGS_RST[LATCH_MSB:0];
      st_q.ie        <= IRQ_ENABLE_RST[LATCH_MSB:0];
      st_q.gates     <= BUS_GATES_RST[11:0];
      st_q.wr_pend   <= 1'b0;
      st_q.wr_addr   <= 8'h00;
      st_q.rdata     <= 32'h0000_0000;
      st_q.ready     <= 1'b1;
      st_q.resp      <= 1'b0;
      st_q.irq_fault <= 1'b0;
      st_q.irq_clock <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata                      = st_q.rdata;
  assign hreadyout                   = st_q.ready;
  assign hresp                       = st_q.resp;
  assign fault_irq                   = st_q.irq_fault;
  assign clock_irq                   = st_q.irq_clock;
  assign cipher_clk_en               = st_q.gates[GATE_CIPHER];
  assign random_source_module_clk_en = st_q.gates[GATE_RANDOM];
  assign io_port_clk_en              = st_q.gates[GATE_PORT_MSB:GATE_PORT_LSB];
  assign checksum_clk_en             = st_q.gates[GATE_CHECKSUM];
  assign flash_cfg_clk_en            = st_q.gates[GATE_FLASH_CFG];
  assign dma_clk_en                  = st_q.gates[GATE_DMA];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic        rd_pend_q;
  logic [7:0]  rd_addr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_pend_q <= take && !hwrite;
      rd_addr_q <= haddr[7:0];
    end
  end

  // Data-phase write hits and expected interrupt levels
  logic        gate_wr;
  logic        ie_wr;
  logic        clear_wr;
  logic        flags_wr;
  logic        fault_want;
  logic        clock_want;
  assign gate_wr    = wr_fire && st_q.wr_addr == BUS_GATES_OFS;
  assign ie_wr      = wr_fire && st_q.wr_addr == IRQ_ENABLE_OFS;
  assign clear_wr   = wr_fire && st_q.wr_addr == EVENT_CLEAR_OFS;
  assign flags_wr   = wr_fire && st_q.wr_addr == EVENT_FLAGS_OFS;
  assign fault_want = |(st_q.flags[8:7] & st_q.ie[8:7]);
  assign clock_want = |(st_q.flags[6:0] & st_q.ie[6:0]);

  a_live_follows_pin: assert property (
    ($stable(osc_stable))[*5] |-> st_q.agreed[4:0] == osc_stable)
    else $error("live stability bits do not follow a steady input");

  a_ready_latches: assert property (
    (rise[4:0] != 5'h00) |=> ((st_q.flags[4:0] & $past(rise[4:0])) == $past(rise[4:0])))
    else $error("ready flag not latched on stability rise");

  a_failure_latches: assert property (
    (rise[8:5] != 4'h0) |=> ((st_q.flags[8:5] & $past(rise[8:5])) == $past(rise[8:5])))
    else $error("failure flag not latched on event");

  a_flags_readback: assert property (
    take && !hwrite && haddr[7:0] == EVENT_FLAGS_OFS |=>
      hrdata == {16'h0000, st_q.agreed[4:0], 2'h0, st_q.flags})
    else $error("flag register read data wrong");

  a_clear_removes: assert property (
    wr_fire && (clr_mask & rise) == 9'h000 && clr_mask != 9'h000 |=>
      (st_q.flags & $past(clr_mask)) == 9'h000)
    else $error("flag survived a zero written to its clear bit");

  a_flag_sticky: assert property (
    (st_q.flags[0] && clr_mask[0] == 1'b0) |=> st_q.flags[0])
    else $error("latched flag dropped without a clear");

  a_clear_reads_ones: assert property (
    rd_pend_q && rd_addr_q == EVENT_CLEAR_OFS |-> hrdata == 32'h0000_01FF)
    else $error("clear register does not read back ones");

  a_gate_write: assert property (
    wr_fire && st_q.wr_addr == BUS_GATES_OFS |=>
      {cipher_clk_en, random_source_module_clk_en, io_port_clk_en, 1'b0,
       checksum_clk_en, flash_cfg_clk_en, dma_clk_en} == ($past(hwdata[11:0]) & 12'hFF7))
    else $error("clock gate outputs do not match written value");

  a_gates_hold: assert property (
    !(wr_fire && st_q.wr_addr == BUS_GATES_OFS) |=> $stable(io_port_clk_en) && $stable(dma_clk_en))
    else $error("clock gates changed without a write");

  a_key_guard: assert property (
    wr_fire && hwdata[31:16] != 16'h5A5A |=> $stable(st_q.ie))
    else $error("interrupt enable changed without the key");

  a_fault_irq: assert property (
    1'b1 |=> fault_irq == $past(fault_want))
    else $error("fault interrupt does not match enabled run failures");

  a_clock_irq: assert property (
    1'b1 |=> clock_irq == $past(clock_want))
    else $error("clock interrupt does not match enabled flags");

  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("slave inserted a wait state or error");

  // ----------------------------------------------------------------
  // Flag checks
  // ----------------------------------------------------------------
  a_live_no_glitch: assert property (
    1'b1 |=>
      (($past(st_q.agreed) ^ st_q.agreed) & ($past(st_q.s2) ^ $past(st_q.s3))) == 9'h000)
    else $error("live status moved while synchroniser stages disagreed");

  a_flag_no_spurious: assert property (
    1'b1 |=>
      (st_q.flags & ~$past(st_q.flags) & ~$past(rise)) == 9'h000)
    else $error("flag set without an event");

  a_flag_no_drop: assert property (
    1'b1 |=>
      ($past(st_q.flags) & ~$past(clr_mask) & ~st_q.flags) == 9'h000)
    else $error("latched flag dropped without its clear bit");

  a_clear_one_keeps: assert property (
    clear_wr |=>
      ($past(st_q.flags) & $past(hwdata[8:0]) & ~st_q.flags) == 9'h000)
    else $error("a one written to the clear register removed a flag");

  a_clear_bit_eight: assert property (
    clear_wr && !hwdata[8] && !rise[8] |=>
      !st_q.flags[8])
    else $error("clear bit 8 did not remove the fast crystal run failure");

  a_flags_write_ignored: assert property (
    flags_wr && rise == 9'h000 |=>
      $stable(st_q.flags))
    else $error("write to the read-only flag register changed it");

  a_loop_ready_flag: assert property (
    $rose(st_q.agreed[2]) |->
      st_q.flags[2])
    else $error("loop ready flag not set when loop became stable");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  a_flags_reserved: assert property (
    rd_pend_q && rd_addr_q == EVENT_FLAGS_OFS |->
      hrdata[31:16] == 16'h0000 && hrdata[10:9] == 2'h0)
    else $error("reserved flag register bits read non-zero");

  a_gates_readback: assert property (
    rd_pend_q && rd_addr_q == BUS_GATES_OFS |->
      hrdata == {20'h00000, cipher_clk_en, random_source_module_clk_en, io_port_clk_en,
                 1'b0, checksum_clk_en, flash_cfg_clk_en, dma_clk_en})
    else $error("clock gate register read does not match gate outputs");

  a_enable_readback: assert property (
    rd_pend_q && rd_addr_q == IRQ_ENABLE_OFS |->
      hrdata[31:9] == 23'h000000)
    else $error("interrupt enable read shows key or reserved bits");

  a_key_write: assert property (
    ie_wr && hwdata[31:16] == 16'h5A5A |=>
      st_q.ie == $past(hwdata[8:0]))
    else $error("keyed write did not load the interrupt enables");

  a_ie_hold: assert property (
    !ie_wr |=>
      $stable(st_q.ie))
    else $error("interrupt enables changed without a write");

  // ----------------------------------------------------------------
  // Gate and interrupt checks
  // ----------------------------------------------------------------
  a_gates_all_hold: assert property (
    !gate_wr |=>
      $stable(st_q.gates))
    else $error("gate register changed without a write");

  a_irq_masked: assert property (
    st_q.ie == 9'h000 |=>
      !fault_irq && !clock_irq)
    else $error("interrupt raised with every enable off");

  a_fault_group: assert property (
    fault_irq |->
      $past(st_q.ie[8:7]) != 2'b00)
    else $error("fault interrupt raised without a run-failure enable");

  a_clock_group: assert property (
    clock_irq |->
      $past(st_q.flags[6:0]) != 7'h00)
    else $error("clock interrupt raised without a clock flag");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  c_gate_on: cover property (wr_fire && st_q.wr_addr == BUS_GATES_OFS ##1 dma_clk_en);
  c_flag_cleared: cover property (st_q.flags[1] ##1 !st_q.flags[1]);
  c_fault_raised: cover property ($rose(fault_irq));
  c_clock_raised: cover property ($rose(clock_irq));
  c_event_latched: cover property (rise[8] ##1 st_q.flags[8]);

endmodule

// ==== verilog/clock_event_pkg.sv ====
// Shared constants and state type of the clock event and gating block
package clock_event_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_ENABLE_OFS  = 8'h0C;
  localparam logic [7:0]  EVENT_FLAGS_OFS = 8'h10;
  localparam logic [7:0]  EVENT_CLEAR_OFS = 8'h14;
  localparam logic [7:0]  BUS_GATES_OFS   = 8'h30;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] EVENT_FLAGS_RST = 32'h0000_0801;
  localparam logic [31:0] EVENT_CLEAR_RB  = 32'h0000_01FF;
  localparam logic [31:0] BUS_GATES_RST   = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_RST  = 32'h0000_0000;
  localparam logic [11:0] BUS_GATES_MASK  = 12'hFF7;
  localparam logic [8:0]  RUN_FAULT_MASK  = 9'h180;
  localparam logic [15:0] IRQ_ENABLE_KEY  = 16'h5A5A;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LIVE_LSB       = 11;
  localparam int LIVE_MSB       = 15;
  localparam int LATCH_MSB      = 8;
  localparam int GATE_CIPHER    = 11;
  localparam int GATE_RANDOM    = 10;
  localparam int GATE_PORT_MSB  = 9;
  localparam int GATE_PORT_LSB  = 4;
  localparam int GATE_CHECKSUM  = 2;
  localparam int GATE_FLASH_CFG = 1;
  localparam int GATE_DMA       = 0;
  localparam int KEY_LSB        = 16;

  // Sync vector: bits 4..0 oscillator stability, bits 8..5 failure events
  localparam logic [8:0]  SYNC_RST = {4'h0, EVENT_FLAGS_RST[LIVE_MSB:LIVE_LSB]};

  typedef struct packed {
    logic [8:0]  s1;
    logic [8:0]  s2;
    logic [8:0]  s3;
    logic [8:0]  agreed;
    logic [8:0]  flags;
    logic [8:0]  ie;
    logic [11:0] gates;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
    logic        irq_fault;
    logic        irq_clock;
  } state_t;

endpackage

// ==== sim/clock_event_flags_and_bus_gating_bench.sv ====
// Self-checking bench for the clock event flags and bus gating block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module clock_event_flags_and_bus_gating_bench;
  import clock_event_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic        hready, hreadyout, hresp, fault_irq, clock_irq;
  logic [4:0]  osc_stable = 5'h01;
  logic        sx_ns = 0, fx_ns = 0, sx_st = 0, fx_st = 0;
  logic        cipher, rnd, chk, flash, dma;
  logic [5:0]  io;
  int          num_errors = 0, compares = 0;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  always @(posedge hclk) rd_q <= hrdata;
  clock_event_flags_and_bus_gating u_clock_event_flags_and_bus_gating (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_stable(osc_stable),
    .slow_xtal_no_start(sx_ns), .fast_xtal_no_start(fx_ns),
    .slow_xtal_stopped(sx_st), .fast_xtal_stopped(fx_st),
    .fault_irq(fault_irq), .clock_irq(clock_irq), .cipher_clk_en(cipher),
    .random_source_module_clk_en(rnd), .io_port_clk_en(io), .checksum_clk_en(chk),
    .flash_cfg_clk_en(flash), .dma_clk_en(dma));
  // ----------------------------------------------------------------
  // Bus and closing tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    #1 rd = rd_q;
    `CHK(hresp, 1'b0)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    `CHK(v, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_0801);
    rd_chk(EVENT_CLEAR_OFS, 32'h0000_01FF);
    rd_chk(BUS_GATES_OFS, 32'h0000_0000);
    `CHK({cipher, rnd, io, chk, flash, dma}, 11'h000)
    rd_chk(8'h20, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_gates();
    wr(BUS_GATES_OFS, 32'h0000_0FF7);
    rd_chk(BUS_GATES_OFS, 32'h0000_0FF7);
    `CHK({cipher, rnd, io, chk, flash, dma}, 11'h7FF)
    wr(BUS_GATES_OFS, 32'h0000_0A45);
    `CHK({cipher, rnd}, 2'b10)
    `CHK(io, 6'h24)
    `CHK({chk, flash, dma}, 3'b101)
    wr(BUS_GATES_OFS, 32'h0000_0002);
    `CHK({cipher, io, chk, flash, dma}, 10'h002)
    $display("clock gates done");
  endtask
  task automatic t_events();
    @(posedge hclk);
    osc_stable <= 5'h1F;
    {sx_ns, fx_ns, sx_st, fx_st} <= 4'hF;
    repeat (6) @(posedge hclk);
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_F9FF);
    @(posedge hclk);
    osc_stable <= 5'h01;
    {sx_ns, fx_ns, sx_st, fx_st} <= 4'h0;
    repeat (6) @(posedge hclk);
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_09FF);
    wr(EVENT_FLAGS_OFS, 32'h0);
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_09FF);
    $display("event flags done");
  endtask
  task automatic t_irq();
    `CHK({fault_irq, clock_irq}, 2'b00)
    wr(IRQ_ENABLE_OFS, 32'h5A5A_0180);
    repeat (2) @(posedge hclk);
    `CHK({fault_irq, clock_irq}, 2'b10)
    wr(IRQ_ENABLE_OFS, 32'h0000_01FF);
    rd_chk(IRQ_ENABLE_OFS, 32'h0000_0180);
    wr(EVENT_CLEAR_OFS, 32'h0000_00FF);
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_08FF);
    `CHK(fault_irq, 1'b1)
    wr(EVENT_CLEAR_OFS, 32'h0000_017F);
    repeat (2) @(posedge hclk);
    `CHK(fault_irq, 1'b0)
    wr(IRQ_ENABLE_OFS, 32'h5A5A_0001);
    repeat (2) @(posedge hclk);
    `CHK({fault_irq, clock_irq}, 2'b01)
    wr(EVENT_CLEAR_OFS, 32'h0000_0000);
    rd_chk(EVENT_FLAGS_OFS, 32'h0000_0800);
    `CHK(clock_irq, 1'b0)
    $display("interrupts done");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gates();
    t_events();
    t_irq();
    conclude();
  end
endmodule
